// *** src/ccm_regs.sv ***
// Collision report and transceive mode register bank with APB slave,
// collision tracker, sync gate, field gates and stand-alone CRC.
// Assumes the decoder delivers bits and bytes in the clk_sys domain.
`timescale 1ns/1ns
module ccm_regs (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic irq,
	input wire logic rx_frame_start,
	input wire ccm_pkg::ccm_rx_bit_t rx_bit,
	output logic rx_bit_kept,
	output logic rx_bit_kept_valid,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	output logic rx_enable,
	output logic tx_sync_prepend,
	input wire logic initiator_mode,
	input wire logic own_field_on,
	input wire logic ext_field_on,
	input wire logic tx_start_req,
	output logic tx_start,
	input wire logic rx_wait_req,
	output logic rx_wait_start,
	input wire logic secure_signal_input,
	output logic envelope_n,
	input wire logic automatic_collision_command_active,
	output logic mode_detector_on,
	input wire logic rf_active,
	input wire logic crc_start,
	input wire logic crc_byte_valid,
	input wire logic [7:0] crc_byte,
	output logic [7:0] crc_result_high,
	output logic [7:0] crc_result_low
);

	////////////////////////////////////////////////////////////////
	// Bus and register state

	ccm_pkg::ccm_mode_cfg_t mode_q, mode_d;
	logic keep_q, keep_d;
	logic [ccm_pkg::IRQ_W-1:0] stat_q, stat_d, en_q, en_d;
	logic [31:0] prdata_q, prdata_d;
	logic err_q, err_d;
	logic setup, wr;
	logic [ccm_pkg::IRQ_W-1:0] evt, clr;

	// Collision tracking state
	logic [ccm_pkg::CNT_W-1:0] cnt_q, cnt_d, cnt_n;
	logic seen_q, seen_d, inv_q, inv_d;
	logic [ccm_pkg::POS_MSB:0] pos_q, pos_d;
	logic kept_q, kept_d, kvalid_q, kvalid_d;
	logic sync_q, sync_d;
	logic coll_evt, sync_evt, sig_evt, data_bit;

	// Gate and CRC state
	logic tx_q, tx_d, rxw_q, rxw_d, env_q, env_d, mdet_q, mdet_d;
	logic [15:0] crc_q, crc_d, res_q, res_d;
	logic msb_q, msb_d;

	////////////////////////////////////////////////////////////////
	// CRC helpers

	// One byte through the CRC, reflected or MSB first
	function automatic logic [15:0] crc_step(
		input logic [15:0] c,
		input logic [7:0] d,
		input logic msb
	);
		logic [15:0] r;
		logic fb;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (msb) begin
				fb = r[15] ^ d[7-i];
				r = {r[14:0], 1'b0} ^ (fb ? ccm_pkg::CRC_POLY : 16'h0000);
			end else begin
				fb = r[0] ^ d[i];
				r = {1'b0, r[15:1]} ^ (fb ? ccm_pkg::CRC_POLY_REV : 16'h0000);
			end
		end
		return r;
	endfunction

	// Reverse bits of a byte for the result view
	function automatic logic [7:0] rev8(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7-i];
		end
		return r;
	endfunction

	// Preset table
	function automatic logic [15:0] preset(input logic [1:0] s);
		logic [15:0] r;
		unique case (s)
			2'h0: r = ccm_pkg::CRC_PRE0;
			2'h1: r = ccm_pkg::CRC_PRE1;
			2'h2: r = ccm_pkg::CRC_PRE2;
			2'h3: r = ccm_pkg::CRC_PRE3;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data latched in setup

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = err_q;
	assign irq = |(stat_q & en_q);

	// Polarity change is an event even when software writes it
	assign sig_evt = wr && paddr == ccm_pkg::ADDR_MODE
		&& pwdata[3] != mode_q.secure_input_polarity; // [R15]
	assign evt = {sync_evt, sig_evt, coll_evt};
	assign clr = (wr && paddr == ccm_pkg::ADDR_IRQ_CLR) ?
		pwdata[ccm_pkg::IRQ_W-1:0] : '0;

	// Register next values and read mux
	always_comb begin
		mode_d = mode_q;
		keep_d = keep_q;
		en_d = en_q;
		prdata_d = prdata_q;
		err_d = 1'b0;
		// Set beats clear in the same cycle
		stat_d = (stat_q & ~clr) | evt;
		if (wr && paddr == ccm_pkg::ADDR_MODE) begin
			mode_d = ccm_pkg::ccm_mode_cfg_t'(pwdata[7:0]);
		end
		if (wr && paddr == ccm_pkg::ADDR_COLL) begin
			keep_d = pwdata[ccm_pkg::KEEP_BIT];
		end
		if (wr && paddr == ccm_pkg::ADDR_IRQ_EN) begin
			en_d = pwdata[ccm_pkg::IRQ_W-1:0];
		end
		if (setup) begin
			prdata_d = 32'h0000_0000;
			unique case (paddr)
				ccm_pkg::ADDR_MODE: prdata_d[7:0] = mode_q;
				ccm_pkg::ADDR_COLL: prdata_d[7:0] = {keep_q, 1'b0, inv_q, pos_q};
				ccm_pkg::ADDR_IRQ_STAT: prdata_d[ccm_pkg::IRQ_W-1:0] = stat_q;
				ccm_pkg::ADDR_IRQ_CLR: prdata_d = 32'h0000_0000;
				ccm_pkg::ADDR_IRQ_EN: prdata_d[ccm_pkg::IRQ_W-1:0] = en_q;
				default: err_d = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			mode_q <= ccm_pkg::MODE_RST;
			keep_q <= ccm_pkg::KEEP_RST;
			stat_q <= '0;
			en_q <= '0;
			prdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			keep_q <= keep_d;
			stat_q <= stat_d;
			en_q <= en_d;
			prdata_q <= prdata_d;
			err_q <= err_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Collision tracker and sync gate

	assign data_bit = rx_bit.valid && rx_bit.is_data;
	assign cnt_n = (cnt_q == ccm_pkg::CNT_MAX) ? cnt_q : cnt_q + 6'h01;
	assign coll_evt = !rx_frame_start && data_bit && rx_bit.collision && !seen_q;
	assign sync_evt = !rx_frame_start && rx_byte_valid && !sync_q
		&& mode_q.sync_byte_detect && rx_byte == ccm_pkg::SYNC_BYTE;

	// Frame start rearms; only the first collision is recorded
	always_comb begin
		cnt_d = cnt_q;
		seen_d = seen_q;
		inv_d = inv_q;
		pos_d = pos_q;
		sync_d = sync_q;
		if (rx_frame_start) begin
			cnt_d = '0;
			seen_d = 1'b0;
			inv_d = 1'b1; // [R3]
			sync_d = 1'b0;
		end else begin
			// Framing and parity bits are not counted
			if (data_bit) begin
				cnt_d = cnt_n; // [R4]
			end
			if (coll_evt) begin
				seen_d = 1'b1;
				// Bit 32 wraps to 00h in the five-bit field
				if (cnt_n <= ccm_pkg::POS_RANGE) begin
					pos_d = cnt_n[ccm_pkg::POS_MSB:0]; // [R5]
					inv_d = 1'b0;
				end else begin
					inv_d = 1'b1; // [R3]
				end
			end
			if (sync_evt) begin
				sync_d = 1'b1; // [R9]
			end
		end
	end

	// Bits behind a collision are zeroed unless kept
	always_comb begin
		kvalid_d = rx_bit.valid;
		kept_d = rx_bit.value && !(seen_q && !keep_q); // [R1]
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cnt_q <= '0;
			seen_q <= 1'b0;
			inv_q <= 1'b1;
			pos_q <= '0;
			sync_q <= 1'b0;
			kept_q <= 1'b0;
			kvalid_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			seen_q <= seen_d;
			inv_q <= inv_d;
			pos_q <= pos_d;
			sync_q <= sync_d;
			kept_q <= kept_d;
			kvalid_q <= kvalid_d;
		end
	end

	assign rx_bit_kept = kept_q;
	assign rx_bit_kept_valid = kvalid_q;
	// Receiver held off until the sync byte is seen
	assign rx_enable = !mode_q.sync_byte_detect || sync_q; // [R9]
	assign tx_sync_prepend = mode_q.sync_byte_detect; // [R9]

	////////////////////////////////////////////////////////////////
	// Field gates, polarity, detector and CRC

	always_comb begin
		// Requests denied by a missing field are dropped, not queued
		tx_d = tx_start_req && (own_field_on
			|| !(mode_q.tx_wait_own_field && initiator_mode)); // [R11]
		rxw_d = rx_wait_req && (ext_field_on
			|| !(mode_q.rx_wait_external_field && !initiator_mode)); // [R12]
		// Envelope is active low whatever the pin polarity
		env_d = mode_q.secure_input_polarity ?
			!secure_signal_input : secure_signal_input; // [R13] [R14]
		mdet_d = automatic_collision_command_active && !mode_q.data_mode_detector_disable; // [R16]
		crc_d = crc_q;
		// RF traffic forces reflected order
		msb_d = msb_q && !rf_active; // [R8]
		if (crc_start) begin
			crc_d = preset(mode_q.crc_preset_select); // [R17]
			msb_d = mode_q.crc_high_bit_order && !rf_active; // [R7] [R8]
		end else if (crc_byte_valid) begin
			crc_d = crc_step(crc_q, crc_byte, msb_q); // [R7]
		end
		res_d = msb_d ? {rev8(crc_d[15:8]), rev8(crc_d[7:0])} : crc_d; // [R7]
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			tx_q <= 1'b0;
			rxw_q <= 1'b0;
			env_q <= 1'b1;
			mdet_q <= 1'b0;
			crc_q <= 16'h0000;
			msb_q <= 1'b0;
			res_q <= 16'h0000;
		end else begin
			tx_q <= tx_d;
			rxw_q <= rxw_d;
			env_q <= env_d;
			mdet_q <= mdet_d;
			crc_q <= crc_d;
			msb_q <= msb_d;
			res_q <= res_d;
		end
	end

	assign tx_start = tx_q;
	assign rx_wait_start = rxw_q;
	assign envelope_n = env_q;
	assign mode_detector_on = mdet_q;
	assign crc_result_high = res_q[15:8];
	assign crc_result_low = res_q[7:0];

	////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_first_coll;
		!rx_frame_start && data_bit && rx_bit.collision && !seen_q;
	endsequence

	sequence s_pol_write;
		wr && paddr == ccm_pkg::ADDR_MODE
			&& pwdata[3] != mode_q.secure_input_polarity;
	endsequence

	chk_pos_value: assert property ( // [R5]
		s_first_coll ##0 (cnt_q < ccm_pkg::POS_RANGE) |=>
			!inv_q && pos_q == 5'($past(cnt_q) + 6'h01))
		else $error("collision position wrong");

	chk_pos_range: assert property ( // [R3]
		s_first_coll ##0 (cnt_q >= ccm_pkg::POS_RANGE) |=> inv_q)
		else $error("out of range collision not invalid");

	chk_frame_inv: assert property ( // [R3]
		rx_frame_start |=> inv_q && !seen_q)
		else $error("frame start did not rearm");

	chk_pos_first: assert property ( // [R4]
		seen_q && !rx_frame_start |=> $stable(pos_q) && $stable(inv_q))
		else $error("later collision overwrote position");

	chk_bits_cleared: assert property ( // [R1]
		seen_q && !keep_q && rx_bit.valid |=> rx_bit_kept_valid && !rx_bit_kept)
		else $error("bit after collision not cleared");

	chk_bits_kept: assert property ( // [R1]
		keep_q && rx_bit.valid |=> rx_bit_kept == $past(rx_bit.value))
		else $error("kept bit changed");

	chk_sync_gate: assert property ( // [R9]
		mode_q.sync_byte_detect && !sync_q |-> !rx_enable)
		else $error("receiver open before sync byte");

	chk_tx_field: assert property ( // [R11]
		tx_start |-> $past(own_field_on)
			|| !$past(mode_q.tx_wait_own_field && initiator_mode))
		else $error("transmit started without own field");

	chk_rxw_field: assert property ( // [R12]
		rx_wait_start |-> $past(ext_field_on)
			|| !$past(mode_q.rx_wait_external_field && !initiator_mode))
		else $error("receive wait started without field");

	chk_env_pol: assert property ( // [R13]
		1'b1 |=> envelope_n == ($past(mode_q.secure_input_polarity)
			^ $past(secure_signal_input)))
		else $error("envelope polarity wrong");

	chk_pol_event: assert property ( // [R15]
		s_pol_write |=> stat_q[ccm_pkg::IRQ_SIG] ##1 stat_q[ccm_pkg::IRQ_SIG]
			|| $past(clr[ccm_pkg::IRQ_SIG]))
		else $error("polarity change raised no event");

	chk_crc_preset: assert property ( // [R17]
		crc_start |=> crc_q == preset($past(mode_q.crc_preset_select)))
		else $error("CRC preset wrong");

	chk_crc_rf: assert property ( // [R8]
		rf_active |=> !msb_q)
		else $error("bit order applied during RF");

	chk_mode_det: assert property ( // [R16]
		mode_q.data_mode_detector_disable |=> !mode_detector_on)
		else $error("detector on while disabled");

endmodule

// *** common/ccm_pkg.sv ***
// Constants, layouts and carriers for the collision report and
// transceive mode configuration register bank.
// Assumes an APB master with 32-bit data and one clock domain.
// Contract
// [R1] Keep-bits control 0 clears every received bit after a collision.
// [R2] Software clears keep-bits only for 106 kbit/s bitwise anticollision.
// [R3] Position-invalid flag is 1 with no collision or position beyond 32.
// [R4] Position field records the first collision, counting data bits only.
// [R5] Position 01h is bit one, 08h bit eight, 00h bit thirty-two.
// [R6] Software reads the position only in 106 kbit/s modes, flag clear.
// [R7] High bit order computes CRC MSB first and reverses result bits.
// [R8] Bit order control is ignored during RF communication.
// [R9] Sync detect holds receiver until F0h and prepends F0h on transmit.
// [R10] Software enables sync detect only for 106 kbit/s peer data exchange.
// [R11] Transmit-wait starts initiator transmitter only with own field on.
// [R12] Receive-wait starts target wait counter only with external field.
// [R13] Secure input is active high at polarity 1, active low at 0.
// [R14] Internal envelope signal is always active low.
// [R15] Changing the polarity control raises the secure input event.
// [R16] Detector disable switches the data mode detector off.
// [R17] CRC preset selects 0000, 6363, A671 or FFFF.
package ccm_pkg;

	// Printed register indices; byte address is four times the index
	localparam logic [15:0] IDX_MODE = 16'h6301;
	localparam logic [15:0] IDX_COLL = 16'h633E;
	localparam logic [31:0] ADDR_MODE = {14'h0, IDX_MODE, 2'h0};
	localparam logic [31:0] ADDR_COLL = {14'h0, IDX_COLL, 2'h0};
	localparam logic [31:0] ADDR_IRQ_STAT = 32'h0001_8D00;
	localparam logic [31:0] ADDR_IRQ_CLR = 32'h0001_8D04;
	localparam logic [31:0] ADDR_IRQ_EN = 32'h0001_8D08;

	// Reset values
	localparam logic [7:0] MODE_RST = 8'h3B;
	localparam logic KEEP_RST = 1'h1;

	// Collision report field positions
	localparam int KEEP_BIT = 7;
	localparam int INV_BIT = 5;
	localparam int POS_MSB = 4;

	// Interrupt status bits
	localparam int IRQ_W = 3;
	localparam int IRQ_COLL = 0;
	localparam int IRQ_SIG = 1;
	localparam int IRQ_SYNC = 2;

	// Collision position range and counter
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] POS_RANGE = 6'h20;
	localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;

	// Sync byte and CRC constants
	localparam logic [7:0] SYNC_BYTE = 8'hF0;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_POLY_REV = 16'h8408;
	localparam logic [15:0] CRC_PRE0 = 16'h0000;
	localparam logic [15:0] CRC_PRE1 = 16'h6363;
	localparam logic [15:0] CRC_PRE2 = 16'hA671;
	localparam logic [15:0] CRC_PRE3 = 16'hFFFF;

	// Mode register layout, bit 7 first
	typedef struct packed {
		logic crc_high_bit_order;
		logic sync_byte_detect;
		logic tx_wait_own_field;
		logic rx_wait_external_field;
		logic secure_input_polarity;
		logic data_mode_detector_disable;
		logic [1:0] crc_preset_select;
	} ccm_mode_cfg_t;

	// One received bit from the decoder
	typedef struct packed {
		logic valid;
		logic is_data;
		logic collision;
		logic value;
	} ccm_rx_bit_t;

endpackage

// *** dv/ccm_rf_model.sv ***
// Far-side model: decoder bit stream, received bytes and RF field levels.
// Assumes one bench process calls its tasks, one at a time, on clk_sys.
`timescale 1ns/1ns
module ccm_rf_model (
	input wire logic clk_sys,
	output logic rx_frame_start,
	output ccm_pkg::ccm_rx_bit_t rx_bit,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic own_field_on,
	output logic ext_field_on
);
	////////////////////////////////////////////////////////////////////////
	// Quiet lines at time zero, no field present
	initial begin
		rx_frame_start = 1'b0;
		rx_bit = '0;
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		own_field_on = 1'b0;
		ext_field_on = 1'b0;
	end

	// Frame of n data bits, collision on data bit c, parity bit after bit one
	task automatic frame(input int n, input int c);
		@(posedge clk_sys);
		rx_frame_start <= 1'b1;
		for (int i = 1; i <= n; i++) begin
			@(posedge clk_sys);
			rx_frame_start <= 1'b0;
			rx_bit <= '{valid: 1'b1, is_data: 1'b1, collision: (i == c), value: 1'b1};
			if (i == 1) begin
				@(posedge clk_sys);
				rx_bit.is_data <= 1'b0; // Framing bit, never counted
			end
		end
		@(posedge clk_sys);
		rx_frame_start <= 1'b0;
		// Released: every field of the bit returns to zero
		rx_bit <= '{valid: 1'b0, is_data: 1'b0, collision: 1'b0, value: 1'b0};
	endtask

	// One received byte, bus inverted once released
	task automatic send_byte(input logic [7:0] b);
		@(posedge clk_sys);
		rx_byte_valid <= 1'b1;
		rx_byte <= b;
		@(posedge clk_sys);
		rx_byte_valid <= 1'b0;
		rx_byte <= ~b;
	endtask

	// Field levels seen at the antenna
	task automatic fields(input logic own, input logic ext);
		@(posedge clk_sys);
		own_field_on <= own;
		ext_field_on <= ext;
	endtask
endmodule

// *** dv/tb_collision_and_mode_config.sv ***
// Self-checking bench for the collision report and mode register bank.
// Assumes ccm_pkg is compiled first; APB master and RF model drive inputs.
`timescale 1ns/1ns
module tb_collision_and_mode_config;
	logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [31:0] paddr, pwdata, prdata, rd, err;
	logic rx_frame_start, rx_bit_kept, rx_bit_kept_valid, rx_byte_valid, rx_enable;
	logic tx_sync_prepend, initiator_mode, own_field_on, ext_field_on, tx_start_req;
	logic tx_start, rx_wait_req, rx_wait_start, secure_signal_input, envelope_n;
	logic automatic_collision_command_active, mode_detector_on, rf_active, crc_start, crc_byte_valid;
	logic [7:0] rx_byte, crc_byte, crc_result_high, crc_result_low, kv;
	ccm_pkg::ccm_rx_bit_t rx_bit;
	int fails, compares, cyc;
	localparam logic [15:0] PRE [4] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};

	ccm_regs ccm_regs_inst (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .irq, .rx_frame_start, .rx_bit, .rx_bit_kept,
		.rx_bit_kept_valid, .rx_byte_valid, .rx_byte, .rx_enable, .tx_sync_prepend,
		.initiator_mode, .own_field_on, .ext_field_on, .tx_start_req, .tx_start,
		.rx_wait_req, .rx_wait_start, .secure_signal_input, .envelope_n, .automatic_collision_command_active,
		.mode_detector_on, .rf_active, .crc_start, .crc_byte_valid, .crc_byte,
		.crc_result_high, .crc_result_low);
	ccm_rf_model ccm_rf_model_inst (.clk_sys, .rx_frame_start, .rx_bit, .rx_byte_valid,
		.rx_byte, .own_field_on, .ext_field_on);

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard; the ceiling is far above the few hundred cycles used
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (rx_bit_kept_valid === 1'b1) kv <= {kv[6:0], rx_bit_kept};
		if (cyc == 20000) begin
			fails++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Comparison and verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t mismatch: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (fails == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// APB transfer; held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = {31'h0, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdv(input logic [31:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset values, access kinds, unmapped address
	task automatic t_regs();
		rdv(ccm_pkg::ADDR_MODE);
		chk(rd, 32'h3B);
		rdv(ccm_pkg::ADDR_COLL);
		chk(rd, 32'hA0);
		wr(ccm_pkg::ADDR_MODE, 32'hFFFFFFFF);
		rdv(ccm_pkg::ADDR_MODE);
		chk(rd, 32'hFF);
		wr(ccm_pkg::ADDR_COLL, 32'h7F);
		rdv(ccm_pkg::ADDR_COLL);
		chk(rd, 32'h20);
		rdv(32'h10);
		chk({err[0], rd[30:0]}, 32'h80000000);
		wr(ccm_pkg::ADDR_COLL, 32'h80);
		wr(ccm_pkg::ADDR_MODE, 32'h3B);
	endtask

	// Collision position, kept bits, event masking and clearing
	task automatic t_coll();
		wr(ccm_pkg::ADDR_IRQ_EN, 32'h0);
		ccm_rf_model_inst.frame(5, 3);
		repeat (3) @(posedge clk_sys);
		chk(kv[5:0], 6'b111111);
		rdv(ccm_pkg::ADDR_COLL);
		chk(rd, 32'h83);
		chk(irq, 1'b0);
		wr(ccm_pkg::ADDR_IRQ_EN, 32'h1);
		rdv(ccm_pkg::ADDR_IRQ_STAT);
		chk({rd[0], irq}, 2'b11);
		wr(ccm_pkg::ADDR_IRQ_CLR, 32'h7);
		rdv(ccm_pkg::ADDR_IRQ_STAT);
		chk({rd[0], irq}, 2'b00);
		wr(ccm_pkg::ADDR_COLL, 32'h0);
		ccm_rf_model_inst.frame(5, 3);
		repeat (3) @(posedge clk_sys);
		chk(kv[5:0], 6'b111100);
		rdv(ccm_pkg::ADDR_COLL);
		chk(rd, 32'h03);
		wr(ccm_pkg::ADDR_COLL, 32'h80);
		ccm_rf_model_inst.frame(32, 32);
		rdv(ccm_pkg::ADDR_COLL);
		chk(rd, 32'h80);
		ccm_rf_model_inst.frame(33, 33);
		rdv(ccm_pkg::ADDR_COLL);
		chk(rd & 32'hE0, 32'hA0);
		wr(ccm_pkg::ADDR_IRQ_EN, 32'h0);
	endtask

	// Pin polarity, envelope level and the change event
	task automatic t_pol();
		secure_signal_input <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk(envelope_n, 1'b0);
		wr(ccm_pkg::ADDR_IRQ_CLR, 32'h7);
		wr(ccm_pkg::ADDR_MODE, 32'h33);
		repeat (2) @(posedge clk_sys);
		chk(envelope_n, 1'b1);
		rdv(ccm_pkg::ADDR_IRQ_STAT);
		chk(rd & 32'h2, 32'h2);
		wr(ccm_pkg::ADDR_IRQ_CLR, 32'h7);
		wr(ccm_pkg::ADDR_MODE, 32'h33);
		rdv(ccm_pkg::ADDR_IRQ_STAT);
		chk(rd & 32'h2, 32'h0);
		wr(ccm_pkg::ADDR_MODE, 32'h3B);
	endtask

	// Receiver held until the sync byte; prepend flag follows the control
	task automatic t_sync();
		wr(ccm_pkg::ADDR_MODE, 32'h7B);
		@(posedge clk_sys);
		chk(tx_sync_prepend, 1'b1);
		ccm_rf_model_inst.frame(0, 0);
		ccm_rf_model_inst.send_byte(8'h55);
		repeat (2) @(posedge clk_sys);
		chk(rx_enable, 1'b0);
		ccm_rf_model_inst.send_byte(8'hF0);
		repeat (2) @(posedge clk_sys);
		chk(rx_enable, 1'b1);
		wr(ccm_pkg::ADDR_MODE, 32'h3B);
		@(posedge clk_sys);
		chk(tx_sync_prepend, 1'b0);
	endtask

	// One start request against the field gates
	task automatic gate(input logic init, input logic own, input logic ext, input logic exp);
		ccm_rf_model_inst.fields(own, ext);
		initiator_mode <= init;
		@(posedge clk_sys);
		tx_start_req <= init;
		rx_wait_req <= !init;
		@(posedge clk_sys);
		tx_start_req <= 1'b0;
		rx_wait_req <= 1'b0;
		@(negedge clk_sys);
		chk(init ? tx_start : rx_wait_start, exp);
	endtask
	task automatic t_gate();
		gate(1'b1, 1'b0, 1'b1, 1'b0);
		gate(1'b1, 1'b1, 1'b0, 1'b1);
		gate(1'b0, 1'b1, 1'b0, 1'b0);
		gate(1'b0, 1'b0, 1'b1, 1'b1);
		wr(ccm_pkg::ADDR_MODE, 32'h0B);
		gate(1'b1, 1'b0, 1'b0, 1'b1);
		gate(1'b0, 1'b0, 1'b0, 1'b1);
		wr(ccm_pkg::ADDR_MODE, 32'h3B);
	endtask

	// Detector enable, then CRC presets and bit order
	task automatic crc_load(input logic [15:0] exp);
		@(posedge clk_sys);
		crc_start <= 1'b1;
		@(posedge clk_sys);
		crc_start <= 1'b0;
		@(posedge clk_sys);
		chk({crc_result_high, crc_result_low}, exp);
	endtask
	// One byte through the CRC, result a cycle later
	task automatic crc_feed(input logic [7:0] b, input logic [15:0] exp);
		@(posedge clk_sys);
		crc_byte_valid <= 1'b1;
		crc_byte <= b;
		@(posedge clk_sys);
		crc_byte_valid <= 1'b0;
		@(posedge clk_sys);
		chk({crc_result_high, crc_result_low}, exp);
	endtask
	task automatic t_misc();
		automatic_collision_command_active <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk(mode_detector_on, 1'b1);
		wr(ccm_pkg::ADDR_MODE, 32'h3F);
		repeat (2) @(posedge clk_sys);
		chk(mode_detector_on, 1'b0);
		for (int s = 0; s < 4; s++) begin
			wr(ccm_pkg::ADDR_MODE, 32'h38 | s);
			crc_load(PRE[s]);
		end
		wr(ccm_pkg::ADDR_MODE, 32'hB9);
		crc_load(16'hC6C6);
		rf_active <= 1'b1;
		crc_load(16'h6363);
		rf_active <= 1'b0;
		wr(ccm_pkg::ADDR_MODE, 32'hB8);
		crc_load(16'h0000);
		crc_feed(8'h01, 16'h0884);
		wr(ccm_pkg::ADDR_MODE, 32'h38);
		crc_load(16'h0000);
		crc_feed(8'h80, 16'h8408);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{resetn, psel, penable, pwrite, initiator_mode, tx_start_req, rx_wait_req} = '0;
		{secure_signal_input, automatic_collision_command_active, rf_active, crc_start, crc_byte_valid} = '0;
		{paddr, pwdata, crc_byte, kv, fails, compares, cyc} = '0;
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		t_regs();
		t_coll();
		t_pol();
		t_sync();
		t_gate();
		t_misc();
		final_report();
	end
endmodule
